// File: inc/src_pkg.sv
// Constants and types for the serial real-time clock core
package src_pkg;
  localparam int         CLK_PERIOD_NS  = 25;
  localparam int         OSC_HALT_NS    = 100000;
  localparam int         OSC_HALT_CYC   = (OSC_HALT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         HALT_W         = 12;
  localparam int         XTAL_EDGES_SEC = 32768;
  localparam int         ASYNC_W        = 6;
  localparam int         ADDR_W         = 12;
  localparam int         REG_NUM        = 14;
  // Byte address of a register is four times its index
  localparam logic [3:0] IDX_SEC        = 4'h0;
  localparam logic [3:0] IDX_MIN        = 4'h1;
  localparam logic [3:0] IDX_HOUR       = 4'h2;
  localparam logic [3:0] IDX_WDAY       = 4'h3;
  localparam logic [3:0] IDX_DAY        = 4'h4;
  localparam logic [3:0] IDX_MON        = 4'h5;
  localparam logic [3:0] IDX_YEAR       = 4'h6;
  localparam logic [3:0] IDX_ADJ        = 4'h7;
  localparam logic [3:0] IDX_AWMIN      = 4'h8;
  localparam logic [3:0] IDX_AWHOUR     = 4'h9;
  localparam logic [3:0] IDX_AWDAYS     = 4'hA;
  localparam logic [3:0] IDX_ADMIN      = 4'hB;
  localparam logic [3:0] IDX_ADHOUR     = 4'hC;
  localparam logic [3:0] IDX_CTRL       = 4'hD;
  localparam logic [3:0] IDX_STS        = 4'hE;
  localparam logic [3:0] IDX_MASK       = 4'hF;
  localparam int         CTL_H24        = 3;
  localparam int         CTL_IHALT      = 4;
  localparam int         CTL_SCOFF      = 5;
  localparam int         CTL_THR        = 6;
  localparam int         ST_AW          = 0;
  localparam int         ST_AD          = 1;
  localparam int         ST_PER         = 2;
  localparam int         ST_OSC         = 3;
  localparam int         ST_SUP         = 4;
  localparam int         HR_PM_BIT      = 5;
  localparam int         CMD_RD_BIT     = 7;
  localparam logic [7:0] STS_RST        = 8'h08;
  localparam logic [7:0] MASK_RST       = 8'h00;
  localparam logic [7:0] REG_RST [0:REG_NUM-1] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
  localparam logic [7:0] BCD_59         = 8'h59;
  localparam logic [7:0] HR_23          = 8'h23;
  localparam logic [4:0] HR12_ONE       = 5'h01;
  localparam logic [4:0] HR12_LAST      = 5'h11;
  localparam logic [4:0] HR12_TOP       = 5'h12;
  localparam logic [7:0] FIRST_BCD      = 8'h01;
  localparam logic [7:0] WDAY_MAX       = 8'h06;
  localparam logic [7:0] MON_FEB        = 8'h02;
  localparam logic [7:0] MON_APR        = 8'h04;
  localparam logic [7:0] MON_JUN        = 8'h06;
  localparam logic [7:0] MON_SEP        = 8'h09;
  localparam logic [7:0] MON_NOV        = 8'h11;
  localparam logic [7:0] MON_MAX        = 8'h12;
  localparam logic [7:0] YR_MAX         = 8'h99;
  localparam logic [7:0] DAYS_28        = 8'h28;
  localparam logic [7:0] DAYS_29        = 8'h29;
  localparam logic [7:0] DAYS_30        = 8'h30;
  localparam logic [7:0] DAYS_31        = 8'h31;

  typedef enum logic [2:0] {
    PER_OFF   = 3'b000,
    PER_HALF  = 3'b001,
    PER_SEC   = 3'b010,
    PER_MIN   = 3'b011,
    PER_HOUR  = 3'b100,
    PER_DAY   = 3'b101,
    PER_MONTH = 3'b110,
    PER_NONE  = 3'b111
  } src_period_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_CMD  = 2'b01,
    LK_WR   = 2'b10,
    LK_RD   = 2'b11
  } src_link_t;
endpackage

// File: tb/src_host.sv
// Host model that drives the four-line serial link
`timescale 1ns/1ps
module src_host (
  input  wire logic clk,
  input  wire logic soOut,
  input  wire logic soOeN,
  output logic      ceIn = 1'b0,
  output logic      sclkIn = 1'b0,
  output logic      siIn = 1'b0
);
  // Half a link clock period; the link clock rests low between frames
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // Command byte then one data byte, MSB first
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    ceIn <= 1'b1;
    half();
    for (int i = 15; i >= 0; i--) begin
      siIn <= sh[i];
      half();
      sclkIn <= 1'b1;
      @(posedge clk);
      // A released output must not pass for data
      if (i < 8) rd[i] = (soOeN === 1'b0) ? soOut : 1'bx;
      repeat (3) @(posedge clk);
      sclkIn <= 1'b0;
    end
    half();
    ceIn <= 1'b0;
    siIn <= ~siIn;
    half();
    half();
  endtask
endmodule

// File: tb/src_rtc_core_tb.sv
// Self-checking bench for the serial real-time clock core
`timescale 1ns/1ps
module src_rtc_core_tb;
  import src_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic              xtalIn = 1'b0;
  logic              belowHiIn = 1'b0;
  logic              belowLoIn = 1'b0;
  logic              xtalRun = 1'b1;
  logic [31:0]       prdata;
  logic              pready, pslverr, irq, soOut, soOeN, irqPinN, irqOeN, slowPin, slowOeN;
  logic              ceIn, sclkIn, siIn;
  logic              slowOeNFix;
  int                mismatches = 0;
  int                nTests = 0;
  int                xCnt = 0;

  src_rtc_core #(.SLOW_CLK_CTRL(1'b1), .PRE_SEC(64)) src_rtc_core_i (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .ceIn(ceIn), .sclkIn(sclkIn), .siIn(siIn), .soOut(soOut), .soOeN(soOeN),
    .xtalIn(xtalIn), .belowHiIn(belowHiIn), .belowLoIn(belowLoIn), .irq_out_n(irqPinN),
    .irqOeN(irqOeN), .slow_clock_out(slowPin), .slowOeN(slowOeN));
  // Fixed variant shares bus and pins; only its slow clock is watched
  src_rtc_core #(.SLOW_CLK_CTRL(1'b0), .PRE_SEC(64)) src_rtc_core_fix_i (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .irq(), .ceIn(ceIn), .sclkIn(sclkIn), .siIn(siIn), .soOut(), .soOeN(),
    .xtalIn(xtalIn), .belowHiIn(belowHiIn), .belowLoIn(belowLoIn), .irq_out_n(),
    .irqOeN(), .slow_clock_out(), .slowOeN(slowOeNFix));
  src_host src_host_i (.clk(clk), .soOut(soOut), .soOeN(soOeN), .ceIn(ceIn),
    .sclkIn(sclkIn), .siIn(siIn));

  initial forever #12.5 clk = ~clk;
  // Fast crystal stand-in keeps a simulated second short
  always @(posedge clk) begin
    xCnt <= (xCnt == 9) ? 0 : xCnt + 1;
    if (xCnt == 9 && xtalRun) xtalIn <= ~xtalIn;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    wrap_up();
  endtask
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  // Entered just after a rising edge; request held until pready is sampled
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      if (++n > 20) tmo();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {6'h00, i, 2'h0}, d, r, e);
  endtask
  task automatic chk(input logic [3:0] i, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, {6'h00, i, 2'h0}, 8'h00, r, e);
    cmp({24'h00_0000, x}, r);
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic e;
    cmp(32'h0000_0001, 32'(irqOeN));
    cmp(32'h0000_0001, 32'(soOeN));
    cmp(32'h0000_0000, {30'h0000_0000, irqPinN, slowPin});
    chk(IDX_STS, 8'h08);
    chk(IDX_DAY, 8'h01);
    apb(1'b0, 12'h040, 8'h00, r, e);
    cmp(32'h0000_0001, 32'(e));
    $display("reset test done");
  endtask
  task automatic t_link();
    logic [7:0] d;
    src_host_i.frame(8'h01, 8'h37, d);
    chk(IDX_MIN, 8'h37);
    src_host_i.frame(8'h81, 8'h00, d);
    cmp(32'h0000_0037, {24'h00_0000, d});
    cmp(32'h0000_0001, 32'(soOeN));
    $display("link test done");
  endtask
  task automatic t_roll();
    logic [7:0] cs [3][7];
    logic [31:0] r;
    logic e;
    int n;
    // Control, year, hour, then expected hour, day, month, alarm flags after one second
    cs = '{'{8'h08, 8'h24, 8'h23, 8'h00, 8'h29, 8'h02, 8'h03},
           '{8'h08, 8'h23, 8'h23, 8'h00, 8'h01, 8'h03, 8'h02},
           '{8'h00, 8'h23, 8'h11, 8'h32, 8'h28, 8'h02, 8'h00}};
    // Weekday alarm only on weekday 1; both alarms at 00:00
    wr(IDX_AWDAYS, 8'h02);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_STS, 8'hFF);
      wr(IDX_CTRL, cs[k][0]);
      wr(IDX_YEAR, cs[k][1]);
      wr(IDX_MON, 8'h02);
      wr(IDX_DAY, 8'h28);
      wr(IDX_HOUR, cs[k][2]);
      wr(IDX_MIN, 8'h59);
      wr(IDX_SEC, 8'h59);
      n = 0;
      do begin
        apb(1'b0, {6'h00, IDX_SEC, 2'h0}, 8'h00, r, e);
        if (++n > 600) tmo();
      end while (r === 32'h0000_0059);
      cmp(32'h0000_0000, r);
      chk(IDX_MIN, 8'h00);
      chk(IDX_HOUR, cs[k][3]);
      chk(IDX_DAY, cs[k][4]);
      chk(IDX_MON, cs[k][5]);
      chk(IDX_STS, cs[k][6]);
    end
    $display("rollover test done");
  endtask
  task automatic t_irq();
    logic [7:0] pc [3];
    logic [7:0] ac [3];
    int pe [3];
    int n;
    // Period select, adjustment, then expected cycles between events
    pc = '{8'h09, 8'h0A, 8'h0A};
    ac = '{8'h00, 8'h00, 8'h10};
    pe = '{640, 1280, 960};
    wr(IDX_MASK, 8'h04);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CTRL, pc[k]);
      wr(IDX_ADJ, ac[k]);
      wr(IDX_STS, 8'hFF);
      // Registered interrupt lags the clear by one cycle
      repeat (2) @(posedge clk);
      n = 0;
      while (irq !== 1'b1) begin
        @(posedge clk);
        if (++n > 3000) tmo();
      end
      repeat (3) @(posedge clk);
      cmp(32'h0000_0000, 32'(irqOeN));
      chk(IDX_STS, 8'h04);
      wr(IDX_STS, 8'h04);
      repeat (2) @(posedge clk);
      n = 0;
      while (irq !== 1'b1) begin
        @(posedge clk);
        if (++n > 3000) tmo();
      end
      cmp(32'h0000_0001, 32'(n > pe[k] - 40 && n < pe[k]));
    end
    wr(IDX_CTRL, 8'h1A);
    repeat (3) @(posedge clk);
    cmp(32'h0000_0001, 32'(irqOeN));
    wr(IDX_CTRL, 8'h08);
    wr(IDX_STS, 8'h04);
    repeat (3) @(posedge clk);
    cmp(32'h0000_0000, 32'(irq));
    $display("interrupt test done");
  endtask
  task automatic t_misc();
    int lo;
    int loFix;
    belowHiIn <= 1'b1;
    repeat (6) @(posedge clk);
    wr(IDX_STS, 8'hFF);
    chk(IDX_STS, 8'h00);
    belowHiIn <= 1'b0;
    belowLoIn <= 1'b1;
    repeat (6) @(posedge clk);
    belowLoIn <= 1'b0;
    chk(IDX_STS, 8'h10);
    // Other threshold selected: now the high comparator counts
    wr(IDX_CTRL, 8'h48);
    wr(IDX_STS, 8'hFF);
    belowHiIn <= 1'b1;
    repeat (6) @(posedge clk);
    belowHiIn <= 1'b0;
    chk(IDX_STS, 8'h10);
    for (int k = 0; k < 2; k++) begin
      lo = 0;
      loFix = 0;
      repeat (40) begin
        @(posedge clk);
        if (slowOeN === 1'b0) lo++;
        if (slowOeNFix === 1'b0) loFix++;
      end
      cmp(32'(k == 0), 32'(lo > 0));
      cmp(32'h0000_0001, 32'(loFix > 0));
      wr(IDX_CTRL, 8'h28);
      repeat (6) @(posedge clk);
    end
    xtalRun <= 1'b0;
    wr(IDX_STS, 8'hFF);
    repeat (4100) @(posedge clk);
    chk(IDX_STS, 8'h08);
    xtalRun <= 1'b1;
    $display("supply, slow clock and halt test done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_link();
    t_roll();
    t_irq();
    t_misc();
    wrap_up();
  end
endmodule

// File: verilog/src_rtc_core.sv
// Serial real-time clock core with APB register access
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module src_rtc_core #(
  parameter bit SLOW_CLK_CTRL = 1'b1,
  parameter int PRE_SEC       = src_pkg::XTAL_EDGES_SEC
) (
  input  logic                        clk,
  input  logic                        rst_n,
  input  logic                        clkEn,
  input  logic [src_pkg::ADDR_W-1:0]  paddr,
  input  logic                        psel,
  input  logic                        penable,
  input  logic                        pwrite,
  input  logic [31:0]                 pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  logic                        ceIn,
  input  logic                        sclkIn,
  input  logic                        siIn,
  output logic                        soOut,
  output logic                        soOeN,
  input  logic                        xtalIn,
  input  logic                        belowHiIn,
  input  logic                        belowLoIn,
  output logic                        irq_out_n,
  output logic                        irqOeN,
  output logic                        slow_clock_out,
  output logic                        slowOeN
);
  import src_pkg::*;

  logic [ASYNC_W-1:0] asyncIn;
  logic [ASYNC_W-1:0] syncA_r;
  logic [ASYNC_W-1:0] syncB_r;
  logic               ceS, sclkS, siS, xtalS, hiS, loS;
  logic               sclkD_r, xtalD_r;
  logic               sclkRise, sclkFall, xtalRise;
  logic [7:0]         regs_r [0:REG_NUM-1];
  logic [7:0]         sts_r, mask_r, stsClr, evtVec;
  logic [7:0]         tSec, tMin, tHr, tWd, tDay, tMon, tYr, tAdj, ctrl;
  logic [7:0]         secN, minN, hrN, wdN, dayN, monN, yrN, dim;
  logic [4:0]         hr12;
  logic               cSec, cMin, cHr, cDay, cMon, leap;
  logic               hour24, intHalt, scOff, thrSel;
  src_period_t        perSel;
  logic [15:0]        preCnt_r, secLast, halfLast;
  logic               secTick, halfTick, perEvt;
  logic               evtMin, evtHour, evtDay, evtMon;
  logic               almChk_r, matchW, matchD;
  logic [HALT_W-1:0]  haltCnt_r;
  logic               haltEvt, supEvt;
  src_link_t          linkSt_r;
  logic [2:0]         bitCnt_r;
  logic [7:0]         shIn_r, shOut_r, rxByte;
  logic [3:0]         linkIdx_r, apbIdx;
  logic               byteDone, lkWe;
  logic               mapped, apbAcc, apbWe;
  logic               pready_r, pslverr_r, irq_r;
  logic [31:0]        prdata_r;
  logic               soOut_r, soOeN_r, irqOeN_r, slowOeN_r, irqPin_r, slowPin_r;

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) bcdInc = {v[7:4] + 4'h1, 4'h0};
    else bcdInc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] rdReg(input logic [3:0] idx);
    if (idx == IDX_STS) rdReg = sts_r;
    else if (idx == IDX_MASK) rdReg = mask_r;
    else rdReg = regs_r[idx];
  endfunction

  // Pins from outside the clock domain pass two flops first
  assign asyncIn = {belowLoIn, belowHiIn, xtalIn, siIn, sclkIn, ceIn};
  assign {loS, hiS, xtalS, siS, sclkS, ceS} = syncB_r;
  assign sclkRise = sclkS && !sclkD_r;
  assign sclkFall = !sclkS && sclkD_r;
  assign xtalRise = xtalS && !xtalD_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Low reset value stands in for the select pull-down
      syncA_r <= '0;
      syncB_r <= '0;
      sclkD_r <= 1'b0;
      xtalD_r <= 1'b0;
    end else if (clkEn) begin
      syncA_r <= asyncIn;
      syncB_r <= syncA_r;
      sclkD_r <= sclkS;
      xtalD_r <= xtalS;
    end
  end

  assign tSec    = regs_r[IDX_SEC];
  assign tMin    = regs_r[IDX_MIN];
  assign tHr     = regs_r[IDX_HOUR];
  assign tWd     = regs_r[IDX_WDAY];
  assign tDay    = regs_r[IDX_DAY];
  assign tMon    = regs_r[IDX_MON];
  assign tYr     = regs_r[IDX_YEAR];
  assign tAdj    = regs_r[IDX_ADJ];
  assign ctrl    = regs_r[IDX_CTRL];
  assign perSel  = src_period_t'(ctrl[2:0]);
  assign hour24  = ctrl[CTL_H24];
  assign intHalt = ctrl[CTL_IHALT];
  assign scOff   = ctrl[CTL_SCOFF];
  assign thrSel  = ctrl[CTL_THR];
  assign hr12    = tHr[4:0];

  // Every year divisible by four is leap within 2000-2099
  assign leap = tYr[4] ? (tYr[3:0] == 4'h2 || tYr[3:0] == 4'h6)
                       : (tYr[3:0] == 4'h0 || tYr[3:0] == 4'h4 || tYr[3:0] == 4'h8);

  always_comb begin
    if (tMon == MON_FEB) begin
      dim = leap ? DAYS_29 : DAYS_28;
    end else if (tMon == MON_APR || tMon == MON_JUN || tMon == MON_SEP || tMon == MON_NOV) begin
      dim = DAYS_30;
    end else begin
      dim = DAYS_31;
    end
  end

  // BCD carry chain, evaluated on each second tick
  always_comb begin
    cSec = (tSec == BCD_59);
    secN = cSec ? 8'h00 : bcdInc(tSec);
    cMin = cSec && (tMin == BCD_59);
    minN = !cSec ? tMin : (cMin ? 8'h00 : bcdInc(tMin));
    if (hour24) begin
      cHr = cMin && (tHr == HR_23);
      hrN = !cMin ? tHr : (cHr ? 8'h00 : bcdInc(tHr));
    end else begin
      // Twelve-hour form keeps AM/PM in its own bit
      cHr = cMin && tHr[HR_PM_BIT] && (hr12 == HR12_LAST);
      hrN = tHr;
      if (cMin) begin
        if (hr12 == HR12_TOP) hrN = {tHr[7:5], HR12_ONE};
        else if (hr12 == HR12_LAST) hrN = {tHr[7:6], !tHr[HR_PM_BIT], HR12_TOP};
        else hrN = bcdInc(tHr);
      end
    end
    cDay = cHr && (tDay == dim);
    dayN = !cHr ? tDay : (cDay ? FIRST_BCD : bcdInc(tDay));
    wdN  = !cHr ? tWd : ((tWd == WDAY_MAX) ? 8'h00 : tWd + 8'h01);
    cMon = cDay && (tMon == MON_MAX);
    monN = !cDay ? tMon : (cMon ? FIRST_BCD : bcdInc(tMon));
    yrN  = !cMon ? tYr : ((tYr == YR_MAX) ? 8'h00 : bcdInc(tYr));
  end

  // Signed correction shortens or stretches each second
  assign secLast  = 16'(PRE_SEC - 1) - {{9{tAdj[6]}}, tAdj[6:0]};
  assign halfLast = 16'(PRE_SEC / 2 - 1);
  assign secTick  = xtalRise && (preCnt_r >= secLast);
  assign halfTick = (xtalRise && (preCnt_r == halfLast)) || secTick;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preCnt_r <= 16'h0000;
    end else if (clkEn && xtalRise) begin
      preCnt_r <= secTick ? 16'h0000 : preCnt_r + 16'h0001;
    end
  end

  assign evtMin  = secTick && cSec;
  assign evtHour = secTick && cMin;
  assign evtDay  = secTick && cHr;
  assign evtMon  = secTick && cDay;

  always_comb begin
    unique case (perSel)
      PER_HALF:          perEvt = halfTick;
      PER_SEC:           perEvt = secTick;
      PER_MIN:           perEvt = evtMin;
      PER_HOUR:          perEvt = evtHour;
      PER_DAY:           perEvt = evtDay;
      PER_MONTH:         perEvt = evtMon;
      PER_OFF, PER_NONE: perEvt = 1'b0;
    endcase
  end

  // Alarms compare one cycle after the minute rolls, on settled counters
  assign matchW = almChk_r && tMin == regs_r[IDX_AWMIN] && tHr == regs_r[IDX_AWHOUR]
                  && regs_r[IDX_AWDAYS][tWd[2:0]];
  assign matchD = almChk_r && tMin == regs_r[IDX_ADMIN] && tHr == regs_r[IDX_ADHOUR];

  assign haltEvt = (haltCnt_r == HALT_W'(OSC_HALT_CYC - 1));
  assign supEvt  = thrSel ? hiS : loS;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      almChk_r  <= 1'b0;
      haltCnt_r <= '0;
    end else if (clkEn) begin
      almChk_r <= evtMin;
      // Counter saturates, so a dead crystal keeps the flag asserted
      if (xtalRise) haltCnt_r <= '0;
      else if (!haltEvt) haltCnt_r <= haltCnt_r + HALT_W'(1);
    end
  end

  // APB slave: one wait state on every access
  assign mapped = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'b00);
  assign apbIdx = paddr[5:2];
  assign apbAcc = psel && penable;
  assign apbWe  = apbAcc && pready_r && pwrite && mapped;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (clkEn) begin
      pready_r <= apbAcc && !pready_r;
      if (apbAcc && !pready_r) begin
        prdata_r  <= (mapped && !pwrite) ? 32'(rdReg(apbIdx)) : '0;
        pslverr_r <= !mapped;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Serial link
  assign rxByte   = {shIn_r[6:0], siS};
  assign byteDone = sclkRise && (bitCnt_r == 3'd7);
  assign lkWe     = ceS && (linkSt_r == LK_WR) && byteDone;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      linkSt_r  <= LK_IDLE;
      bitCnt_r  <= 3'd0;
      shIn_r    <= '0;
      shOut_r   <= '0;
      linkIdx_r <= '0;
      soOut_r   <= 1'b0;
      soOeN_r   <= 1'b1;
    end else if (clkEn) begin
      soOeN_r <= !(ceS && linkSt_r == LK_RD);
      if (!ceS) begin
        // Frame ends with select; edges outside it are ignored
        linkSt_r <= LK_IDLE;
        bitCnt_r <= 3'd0;
      end else begin
        if (sclkRise && linkSt_r != LK_IDLE) begin
          shIn_r   <= rxByte;
          bitCnt_r <= bitCnt_r + 3'd1;
        end
        unique case (linkSt_r)
          LK_IDLE: linkSt_r <= LK_CMD;
          LK_CMD: begin
            if (byteDone) begin
              linkSt_r  <= rxByte[CMD_RD_BIT] ? LK_RD : LK_WR;
              linkIdx_r <= rxByte[CMD_RD_BIT] ? rxByte[3:0] + 4'h1 : rxByte[3:0];
              shOut_r   <= rdReg(rxByte[3:0]);
            end
          end
          LK_WR: begin
            if (byteDone) linkIdx_r <= linkIdx_r + 4'h1;
          end
          LK_RD: begin
            if (byteDone) begin
              shOut_r   <= rdReg(linkIdx_r);
              linkIdx_r <= linkIdx_r + 4'h1;
            end else if (sclkFall) begin
              soOut_r <= shOut_r[7];
              shOut_r <= {shOut_r[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // Link write wins over a same-cycle bus write to one register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_NUM; i++) regs_r[i] <= REG_RST[i];
    end else if (clkEn) begin
      if (secTick) begin
        regs_r[IDX_SEC]  <= secN;
        regs_r[IDX_MIN]  <= minN;
        regs_r[IDX_HOUR] <= hrN;
        regs_r[IDX_WDAY] <= wdN;
        regs_r[IDX_DAY]  <= dayN;
        regs_r[IDX_MON]  <= monN;
        regs_r[IDX_YEAR] <= yrN;
      end
      if (apbWe && apbIdx < IDX_STS) regs_r[apbIdx] <= pwdata[7:0];
      if (lkWe && linkIdx_r < IDX_STS) regs_r[linkIdx_r] <= rxByte;
    end
  end

  assign evtVec = {3'b000, supEvt, haltEvt, perEvt, matchD, matchW};
  assign stsClr = ((apbWe && apbIdx == IDX_STS) ? pwdata[7:0] : 8'h00)
                | ((lkWe && linkIdx_r == IDX_STS) ? rxByte : 8'h00);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sts_r  <= STS_RST;
      mask_r <= MASK_RST;
    end else if (clkEn) begin
      // Write one to clear; a new event in the same cycle wins
      sts_r <= (sts_r & ~stsClr) | evtVec;
      if (apbWe && apbIdx == IDX_MASK) mask_r <= pwdata[7:0];
      if (lkWe && linkIdx_r == IDX_MASK) mask_r <= rxByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_r     <= 1'b0;
      irqOeN_r  <= 1'b1;
      slowOeN_r <= 1'b1;
      irqPin_r  <= 1'b0;
      slowPin_r <= 1'b0;
    end else if (clkEn) begin
      irq_r    <= |(sts_r & mask_r);
      irqOeN_r <= !((|(sts_r[2:0] & mask_r[2:0])) && !intHalt);
      // Fixed variant keeps the clock running whatever software sets
      slowOeN_r <= (SLOW_CLK_CTRL && scOff) ? 1'b1 : xtalS;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign irq            = irq_r;
  assign soOut          = soOut_r;
  assign soOeN          = soOeN_r;
  assign irq_out_n      = irqPin_r;
  assign irqOeN         = irqOeN_r;
  assign slow_clock_out = slowPin_r;
  assign slowOeN        = slowOeN_r;

  default clocking cbMain @(posedge clk); endclocking
  default disable iff (!rst_n || !clkEn);

  AST_LINK_IDLE: assert property (!ceS |=> linkSt_r == LK_IDLE)
    else $error("link left idle with select low");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> linkSt_r == LK_IDLE && soOeN_r)
    else $error("link not idle after reset");
  AST_RX_BIT: assert property (sclkRise && ceS && linkSt_r != LK_IDLE |=> shIn_r[0] == $past(siS))
    else $error("serial input bit not captured");
  AST_SO_BIT: assert property (linkSt_r == LK_RD && ceS && sclkFall
    |=> soOut_r == $past(shOut_r[7]) && !soOeN_r)
    else $error("serial output bit wrong");
  AST_SO_FREE: assert property (!ceS |=> soOeN_r)
    else $error("serial output driven with select low");
  AST_IRQ_PIN: assert property ((|(sts_r[2:0] & mask_r[2:0])) && !intHalt |=> !irqOeN_r)
    else $error("interrupt pin not pulled");
  AST_IRQ_MASKED: assert property (mask_r[2:0] == 3'b000 |=> irqOeN_r)
    else $error("interrupt pin pulled with sources disabled");
  AST_IRQ_HALT: assert property (intHalt |=> irqOeN_r)
    else $error("interrupt pin pulled while halted");
  AST_SLOW_CLK: assert property (!(SLOW_CLK_CTRL && scOff) |=> slowOeN_r == $past(xtalS))
    else $error("slow clock not following crystal");
  AST_PER_HALF: assert property (perSel == PER_HALF && halfTick |=> sts_r[ST_PER])
    else $error("half-second event lost");
  AST_ALARM_D: assert property (matchD |=> sts_r[ST_AD])
    else $error("daily alarm not flagged");
  AST_SEC_WRAP: assert property (secTick && cSec && !apbWe && !lkWe |=> tSec == 8'h00)
    else $error("seconds did not wrap");
  AST_LEAP_FEB: assert property (evtDay && tMon == MON_FEB && tDay == DAYS_28 && leap
    && !apbWe && !lkWe |=> tDay == DAYS_29)
    else $error("leap February cut short");
  AST_OSC_HALT: assert property (haltEvt |=> sts_r[ST_OSC])
    else $error("oscillator stop not recorded");
  AST_SUPPLY: assert property (thrSel && hiS |=> sts_r[ST_SUP])
    else $error("supply drop not recorded");
  AST_ADJ: assert property (secTick |=> preCnt_r == 16'h0000)
    else $error("second prescaler did not restart");

  COV_READ_BYTE: cover property (linkSt_r == LK_RD && byteDone);
  COV_ALARM_W: cover property (matchW);
  COV_MONTH: cover property (evtMon);
  COV_SLVERR: cover property (pready_r && pslverr_r);
endmodule
